// *** flash_cmd_defines.svh ***
// Opcodes, status field positions and timing defaults of the command block.
// Assumes a 100 MHz system clock; times are in nanoseconds.
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// Opcodes handled here
`define OP_STATUS    8'hd7
`define OP_DPD       8'hb9
`define OP_RESUME    8'hab
`define OP_CFG1      8'h3d
`define OP_CFG2      8'h2a
`define OP_CFG3      8'h80
`define OP_CFG4      8'ha6

// Status byte field positions
`define ST_RDY       7
`define ST_COMP      6
`define ST_DENS_HI   5
`define ST_DENS_LO   2
`define ST_PROT      1
`define ST_PAGE      0

// Clock and timing defaults
`define CLK_PERIOD_NS   10
`define PD_ENTRY_NS     3000
`define PD_RESUME_NS    30000
`define CFG_PROG_NS     4000000
`define TIMER_W         24

`endif

// *** flash_cmd_pkg.sv ***
// Types of the status, power-down and page-size command block.
// Used by the top module only; nothing is imported.
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_STATUS = 3'b010,
    ST_CFG    = 3'b011,
    ST_SKIP   = 3'b100
  } cmd_state_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ENTER   = 2'b01,
    PWR_DEEP    = 2'b10,
    PWR_RESUME  = 2'b11
  } pwr_state_t;

  typedef enum logic [1:0] {
    PEND_NONE   = 2'b00,
    PEND_DPD    = 2'b01,
    PEND_RESUME = 2'b10,
    PEND_CFG    = 2'b11
  } pend_t;

endpackage : flash_cmd_pkg

// *** pin_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is a slow level against sys_clk; no bus coherence.
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arstN,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pinIn,
  output wire logic [W-1:0] syncOut
);

  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      logic meta_ff;
      logic stable_ff;
      always_ff @(posedge clk or negedge arstN)
      begin
        if (!arstN)
        begin
          meta_ff   <= RST[i];
          stable_ff <= RST[i];
        end
        else
        begin
          meta_ff   <= pinIn[i];
          stable_ff <= meta_ff;
        end
      end
      assign syncOut[i] = stable_ff;
    end
  endgenerate

endmodule : pin_sync

// *** span_timer.sv ***
// Down-counter that measures one self-timed interval.
// Assumes start is a one-cycle pulse; a new start reloads the count.
`timescale 1ns/1ps
module span_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arstN,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] loadVal,
  // State
  output wire logic         busy,
  output wire logic         done
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         done_ff;
  logic         nxt_done;

  // Load on start, count down, pulse done on the last step
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (start)
      nxt_cnt = loadVal;
    else if (cnt_ff != '0)
    begin
      nxt_cnt  = cnt_ff - W'(1);
      nxt_done = (cnt_ff == W'(1));
    end
  end

  always_ff @(posedge clk or negedge arstN)
  begin
    if (!arstN)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;

endmodule : span_timer

// *** status_power_pagesize_commands.sv ***
// Status read, deep power-down and binary page-size commands of a flash.
// Assumes the host drives csN, sck, si and byteIn asynchronously to
// sys_clk, slow enough that synchronised edges are seen one by one.
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"

// Functional notes
// - Opcode D7H returns status from next clock
// - Serial status shifted MSB first, eight clocks
// - Status repeats while clocked, freshly sampled
// - Bit 7 is one when ready
// - Bit 7 clears during array operations
// - Bit 6 holds latest compare mismatch
// - Bit 1 shows sector protection enabled
// - Bit 0 shows binary page size
// - Bits 5..2 carry fixed density code
// - Device starts in standby after power-up
// - B9H then deselect enters deep power-down
// - Deep power-down ignores all but resume
// - ABH then deselect returns to standby
// - Four-byte sequence starts busy config program
// - Binary page size cannot be undone
// - Delivered with 1056-byte pages by default
// - New page size effective after power cycle
// - Busy device takes status reads only; other opcodes are still forwarded while only arrayBusy is set
module status_power_pagesize_commands #(
  parameter logic [3:0] DENSITY_CODE   = 4'h5,  // Arbitrary neutral value
  parameter logic       FACTORY_BINARY = 1'b0,
  parameter int         PD_ENTRY_NS    = `PD_ENTRY_NS,
  parameter int         PD_RESUME_NS   = `PD_RESUME_NS,
  parameter int         CFG_PROG_NS    = `CFG_PROG_NS
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Host link pins
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       portByte,
  input  wire logic [7:0] byteIn,
  output wire logic       soOut,
  output wire logic       soOeN,
  output wire logic [7:0] byteOut,
  output wire logic       byteOeN,
  // Device core state
  input  wire logic       arrayBusy,
  input  wire logic       compareDone,
  input  wire logic       compareMismatch,
  input  wire logic       protectOn,
  input  wire logic       nvCfgBinary,
  // Device core control
  output wire logic       deepPowerDown,
  output wire logic       pageBinary,
  output wire logic       cfgProgStart,
  output wire logic       opcodeValid,
  output wire logic [7:0] opcode
);

  localparam int TW        = `TIMER_W;
  localparam int ENTRY_CYC = (PD_ENTRY_NS / `CLK_PERIOD_NS) < 1 ? 1
                           : PD_ENTRY_NS / `CLK_PERIOD_NS;
  localparam int RES_CYC   = (PD_RESUME_NS / `CLK_PERIOD_NS) < 1 ? 1
                           : PD_RESUME_NS / `CLK_PERIOD_NS;
  localparam int PROG_CYC  = (CFG_PROG_NS / `CLK_PERIOD_NS) < 1 ? 1
                           : CFG_PROG_NS / `CLK_PERIOD_NS;
  localparam int ENTRY_BOUND = ENTRY_CYC + 2;

  // Pin synchronisation; select idles high
  logic [11:0] syncOut;
  logic        csS;
  logic        sckS;
  logic        siS;
  logic        portS;
  logic [7:0]  byteS;

  pin_sync #(.W(12), .RST(12'h800)) u_sync (
    .clk     (sys_clk),
    .arstN   (arst_n),
    .pinIn   ({csN, sck, si, portByte, byteIn}),
    .syncOut (syncOut)
  );
  assign {csS, sckS, siS, portS, byteS} = syncOut;

  // Command state
  flash_cmd_pkg::cmd_state_t cmdState_ff, nxt_cmdState;
  flash_cmd_pkg::pend_t      pend_ff, nxt_pend;
  logic       sckPrev_ff, nxt_sckPrev;
  logic       csPrev_ff, nxt_csPrev;
  logic [2:0] bitCnt_ff, nxt_bitCnt;
  logic [7:0] rxShift_ff, nxt_rxShift;
  logic       byteFrame_ff, nxt_byteFrame;
  logic [1:0] byteIdx_ff, nxt_byteIdx;
  logic [7:0] txReg_ff, nxt_txReg;
  logic [2:0] txCnt_ff, nxt_txCnt;
  logic       soOut_ff, nxt_soOut;
  logic       soOeN_ff, nxt_soOeN;
  logic [7:0] byteOut_ff, nxt_byteOut;
  logic       byteOeN_ff, nxt_byteOeN;
  logic       opValid_ff, nxt_opValid;
  logic [7:0] opcode_ff, nxt_opcode;

  // Power and configuration state
  flash_cmd_pkg::pwr_state_t pwrState_ff, nxt_pwrState;
  logic deepPd_ff, nxt_deepPd;
  logic cfgDone_ff, nxt_cfgDone;
  logic progStart_ff, nxt_progStart;
  logic compMiss_ff, nxt_compMiss;
  logic capDone_ff, nxt_capDone;
  logic pageBin_ff, nxt_pageBin;

  logic          sckRise, sckFall, csFall, csRise, byteDone;
  logic [7:0]    rxByte, statusNow;
  logic          busyAny, cfgBinBit;
  logic          startEntry, startResume, startCfg;
  logic          pwrBusy, pwrDone, cfgBusy, cfgDone;
  logic [TW-1:0] pwrLoad;

  function automatic logic [7:0] cfgSeqByte(input logic [1:0] idx);
    case (idx)
      2'h0:    cfgSeqByte = `OP_CFG1;
      2'h1:    cfgSeqByte = `OP_CFG2;
      2'h2:    cfgSeqByte = `OP_CFG3;
      default: cfgSeqByte = `OP_CFG4;
    endcase
  endfunction : cfgSeqByte

  // Edges of the synchronised link pins
  assign sckRise  = sckS & ~sckPrev_ff;
  assign sckFall  = ~sckS & sckPrev_ff;
  assign csFall   = ~csS & csPrev_ff;
  assign csRise   = csS & ~csPrev_ff;
  assign rxByte   = byteFrame_ff ? byteS : {rxShift_ff[6:0], siS};
  assign byteDone = ~csS & sckRise & (cmdState_ff != flash_cmd_pkg::ST_IDLE)
                  & (byteFrame_ff | (bitCnt_ff == 3'h7));

  // Busy covers every self-timed core operation and the config program
  assign busyAny   = arrayBusy | cfgBusy;
  assign cfgBinBit = nvCfgBinary | FACTORY_BINARY | cfgDone_ff;

  // Live status value; re-read at each byte boundary
  always_comb
  begin
    statusNow                           = 8'h00;
    statusNow[`ST_RDY]                  = ~busyAny;
    statusNow[`ST_COMP]                 = compMiss_ff;
    statusNow[`ST_DENS_HI:`ST_DENS_LO]  = DENSITY_CODE;
    statusNow[`ST_PROT]                 = protectOn;
    statusNow[`ST_PAGE]                 = cfgBinBit;
  end

  // Command decode and status shifting
  always_comb
  begin
    nxt_cmdState  = cmdState_ff;
    nxt_pend      = pend_ff;
    nxt_sckPrev   = sckS;
    nxt_csPrev    = csS;
    nxt_bitCnt    = bitCnt_ff;
    nxt_rxShift   = rxShift_ff;
    nxt_byteFrame = byteFrame_ff;
    nxt_byteIdx   = byteIdx_ff;
    nxt_txReg     = txReg_ff;
    nxt_txCnt     = txCnt_ff;
    nxt_soOut     = soOut_ff;
    nxt_byteOut   = byteOut_ff;
    nxt_opValid   = 1'b0;
    nxt_opcode    = opcode_ff;
    if (csFall)
    begin
      nxt_cmdState  = flash_cmd_pkg::ST_OPCODE;
      nxt_pend      = flash_cmd_pkg::PEND_NONE;
      nxt_bitCnt    = 3'h0;
      nxt_byteFrame = portS;
      nxt_byteIdx   = 2'h0;
      nxt_txCnt     = 3'h0;
    end
    else if (csS)
    begin
      // Pending action is taken by the power group on the rising select
      nxt_cmdState = flash_cmd_pkg::ST_IDLE;
      nxt_pend     = flash_cmd_pkg::PEND_NONE;
    end
    else if (sckRise && cmdState_ff != flash_cmd_pkg::ST_IDLE)
    begin
      nxt_bitCnt  = bitCnt_ff + 3'h1;
      nxt_rxShift = rxByte;
      if (byteDone)
      begin
        case (cmdState_ff)
          flash_cmd_pkg::ST_OPCODE:
          begin
            nxt_cmdState = flash_cmd_pkg::ST_SKIP;
            if (pwrState_ff != flash_cmd_pkg::PWR_STANDBY)
            begin
              if (rxByte == `OP_RESUME && pwrState_ff == flash_cmd_pkg::PWR_DEEP)
                nxt_pend = flash_cmd_pkg::PEND_RESUME;
            end
            else if (rxByte == `OP_STATUS)
            begin
              nxt_cmdState = flash_cmd_pkg::ST_STATUS;
              nxt_txCnt    = 3'h0;
            end
            else if (rxByte == `OP_DPD || rxByte == `OP_CFG1)
            begin
              // Refused while busy: status reads run alongside, other opcodes too while only arrayBusy is set
              if (!busyAny && rxByte == `OP_DPD)
                nxt_pend = flash_cmd_pkg::PEND_DPD;
              else if (!busyAny && !cfgBinBit)
              begin
                nxt_cmdState = flash_cmd_pkg::ST_CFG;
                nxt_byteIdx  = 2'h1;
              end
            end
            else if (!cfgBusy)
            begin
              nxt_opValid = 1'b1;
              nxt_opcode  = rxByte;
            end
          end
          flash_cmd_pkg::ST_CFG:
          begin
            if (rxByte != cfgSeqByte(byteIdx_ff))
              nxt_cmdState = flash_cmd_pkg::ST_SKIP;
            else if (byteIdx_ff == 2'h3)
            begin
              nxt_cmdState = flash_cmd_pkg::ST_SKIP;
              nxt_pend     = flash_cmd_pkg::PEND_CFG;
            end
            else
              nxt_byteIdx = byteIdx_ff + 2'h1;
          end
          // Trailing bytes void a one-byte command
          flash_cmd_pkg::ST_SKIP: nxt_pend = flash_cmd_pkg::PEND_NONE;
          default: ;
        endcase
      end
    end
    // Output changes on the falling edge so the host samples it stable
    if (!csS && sckFall && cmdState_ff == flash_cmd_pkg::ST_STATUS)
    begin
      if (byteFrame_ff)
        nxt_byteOut = statusNow;
      else if (txCnt_ff == 3'h0)
      begin
        nxt_soOut = statusNow[7];
        nxt_txReg = {statusNow[6:0], 1'b0};
        nxt_txCnt = 3'h7;
      end
      else
      begin
        nxt_soOut = txReg_ff[7];
        nxt_txReg = {txReg_ff[6:0], 1'b0};
        nxt_txCnt = txCnt_ff - 3'h1;
      end
    end
    nxt_soOeN   = ~(nxt_cmdState == flash_cmd_pkg::ST_STATUS && !nxt_byteFrame);
    nxt_byteOeN = ~(nxt_cmdState == flash_cmd_pkg::ST_STATUS && nxt_byteFrame);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmdState_ff  <= flash_cmd_pkg::ST_IDLE;
      pend_ff      <= flash_cmd_pkg::PEND_NONE;
      sckPrev_ff   <= 1'b0;
      csPrev_ff    <= 1'b1;
      bitCnt_ff    <= 3'h0;
      rxShift_ff   <= 8'h00;
      byteFrame_ff <= 1'b0;
      byteIdx_ff   <= 2'h0;
      txReg_ff     <= 8'h00;
      txCnt_ff     <= 3'h0;
      soOut_ff     <= 1'b0;
      soOeN_ff     <= 1'b1;
      byteOut_ff   <= 8'h00;
      byteOeN_ff   <= 1'b1;
      opValid_ff   <= 1'b0;
      opcode_ff    <= 8'h00;
    end
    else
    begin
      cmdState_ff  <= nxt_cmdState;
      pend_ff      <= nxt_pend;
      sckPrev_ff   <= nxt_sckPrev;
      csPrev_ff    <= nxt_csPrev;
      bitCnt_ff    <= nxt_bitCnt;
      rxShift_ff   <= nxt_rxShift;
      byteFrame_ff <= nxt_byteFrame;
      byteIdx_ff   <= nxt_byteIdx;
      txReg_ff     <= nxt_txReg;
      txCnt_ff     <= nxt_txCnt;
      soOut_ff     <= nxt_soOut;
      soOeN_ff     <= nxt_soOeN;
      byteOut_ff   <= nxt_byteOut;
      byteOeN_ff   <= nxt_byteOeN;
      opValid_ff   <= nxt_opValid;
      opcode_ff    <= nxt_opcode;
    end
  end

  // Actions start only when select rises after a complete command
  assign startEntry  = csRise & (pend_ff == flash_cmd_pkg::PEND_DPD);
  assign startResume = csRise & (pend_ff == flash_cmd_pkg::PEND_RESUME);
  assign startCfg    = csRise & (pend_ff == flash_cmd_pkg::PEND_CFG);
  assign pwrLoad     = startEntry ? TW'(ENTRY_CYC) : TW'(RES_CYC);

  // Entry and resume never overlap, so they share one timer
  span_timer #(.W(TW)) u_pwrTimer (
    .clk     (sys_clk),
    .arstN   (arst_n),
    .start   (startEntry | startResume),
    .loadVal (pwrLoad),
    .busy    (pwrBusy),
    .done    (pwrDone)
  );

  span_timer #(.W(TW)) u_cfgTimer (
    .clk     (sys_clk),
    .arstN   (arst_n),
    .start   (startCfg),
    .loadVal (TW'(PROG_CYC)),
    .busy    (cfgBusy),
    .done    (cfgDone)
  );

  // Power mode, compare result and page-size configuration
  always_comb
  begin
    nxt_pwrState  = pwrState_ff;
    nxt_cfgDone   = cfgDone_ff | cfgDone;
    nxt_progStart = startCfg;
    nxt_compMiss  = compareDone ? compareMismatch : compMiss_ff;
    nxt_capDone   = 1'b1;
    nxt_pageBin   = pageBin_ff;
    // Effective size caught once after reset release, not on programming
    if (!capDone_ff)
      nxt_pageBin = nvCfgBinary | FACTORY_BINARY;
    case (pwrState_ff)
      flash_cmd_pkg::PWR_STANDBY: if (startEntry) nxt_pwrState = flash_cmd_pkg::PWR_ENTER;
      flash_cmd_pkg::PWR_ENTER:   if (pwrDone) nxt_pwrState = flash_cmd_pkg::PWR_DEEP;
      flash_cmd_pkg::PWR_DEEP:    if (startResume) nxt_pwrState = flash_cmd_pkg::PWR_RESUME;
      flash_cmd_pkg::PWR_RESUME:  if (pwrDone) nxt_pwrState = flash_cmd_pkg::PWR_STANDBY;
      default:                    nxt_pwrState = flash_cmd_pkg::PWR_STANDBY;
    endcase
    nxt_deepPd = (nxt_pwrState == flash_cmd_pkg::PWR_DEEP);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwrState_ff  <= flash_cmd_pkg::PWR_STANDBY;
      deepPd_ff    <= 1'b0;
      cfgDone_ff   <= 1'b0;
      progStart_ff <= 1'b0;
      compMiss_ff  <= 1'b0;
      capDone_ff   <= 1'b0;
      pageBin_ff   <= 1'b0;
    end
    else
    begin
      pwrState_ff  <= nxt_pwrState;
      deepPd_ff    <= nxt_deepPd;
      cfgDone_ff   <= nxt_cfgDone;
      progStart_ff <= nxt_progStart;
      compMiss_ff  <= nxt_compMiss;
      capDone_ff   <= nxt_capDone;
      pageBin_ff   <= nxt_pageBin;
    end
  end

  assign soOut         = soOut_ff;
  assign soOeN         = soOeN_ff;
  assign byteOut       = byteOut_ff;
  assign byteOeN       = byteOeN_ff;
  assign deepPowerDown = deepPd_ff;
  assign pageBinary    = pageBin_ff;
  assign cfgProgStart  = progStart_ff;
  assign opcodeValid   = opValid_ff;
  assign opcode        = opcode_ff;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_serialLoad;
    !csS && sckFall && cmdState_ff == flash_cmd_pkg::ST_STATUS
      && !byteFrame_ff && txCnt_ff == 3'h0;
  endsequence
  sequence s_statusOpcode;
    byteDone && cmdState_ff == flash_cmd_pkg::ST_OPCODE && rxByte == `OP_STATUS
      && pwrState_ff == flash_cmd_pkg::PWR_STANDBY;
  endsequence

  property p_statusEnter;
    s_statusOpcode |=> cmdState_ff == flash_cmd_pkg::ST_STATUS && !soOeN_ff == !byteFrame_ff;
  endproperty
  a_statusEnter: assert property (p_statusEnter) else $error("status not entered");
  property p_msbFirst;
    s_serialLoad |=> soOut_ff == $past(statusNow[7]) && txReg_ff[7] == $past(statusNow[6]);
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("status not MSB first");
  property p_busyBit;
    s_serialLoad and busyAny |=> !soOut_ff;
  endproperty
  a_busyBit: assert property (p_busyBit) else $error("busy not reported");
  property p_compare;
    compareDone |=> statusNow[`ST_COMP] == $past(compareMismatch);
  endproperty
  a_compare: assert property (p_compare) else $error("compare bit wrong");
  // Checked on the driven byte, not on the live value, so a bad load shows
  property p_density;
    !csS && sckFall && cmdState_ff == flash_cmd_pkg::ST_STATUS && byteFrame_ff
      |=> byteOut_ff[`ST_DENS_HI:`ST_DENS_LO] == DENSITY_CODE
      && byteOut_ff[`ST_PROT] == $past(protectOn);
  endproperty
  a_density: assert property (p_density) else $error("fixed status field wrong");
  property p_dpdEntry;
    startEntry |=> pwrState_ff == flash_cmd_pkg::PWR_ENTER ##[0:ENTRY_BOUND] deepPd_ff;
  endproperty
  a_dpdEntry: assert property (p_dpdEntry) else $error("deep power-down late");
  property p_deepIgnore;
    pwrState_ff == flash_cmd_pkg::PWR_DEEP |-> soOeN_ff && byteOeN_ff && !opValid_ff;
  endproperty
  a_deepIgnore: assert property (p_deepIgnore) else $error("command taken in deep mode");
  property p_resume;
    startResume |=> pwrState_ff == flash_cmd_pkg::PWR_RESUME && !deepPd_ff;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not started");
  property p_cfgBusy;
    startCfg |=> progStart_ff && !statusNow[`ST_RDY] ##1 !statusNow[`ST_RDY];
  endproperty
  a_cfgBusy: assert property (p_cfgBusy) else $error("config program not busy");
  property p_oneTime;
    cfgBinBit && byteDone && cmdState_ff == flash_cmd_pkg::ST_OPCODE
      |=> cmdState_ff != flash_cmd_pkg::ST_CFG && statusNow[`ST_PAGE];
  endproperty
  a_oneTime: assert property (p_oneTime) else $error("page size reprogrammed");
  property p_sizeHeld;
    capDone_ff |=> $stable(pageBin_ff);
  endproperty
  a_sizeHeld: assert property (p_sizeHeld) else $error("page size changed live");

endmodule : status_power_pagesize_commands

// *** host_link_model.sv ***
// Host controller model for the serial and byte command pins.
// Assumes sysClk paces every pin change; link clock averages 125 ns.
`timescale 1ns/1ps
module host_link_model (
  // Clock
  input  wire logic       sysClk,
  // Link pins driven by the host
  output logic            csN,
  output logic            sck,
  output logic            si,
  output logic            portByte,
  output logic [7:0]      byteIn,
  // Link pins driven by the device
  input  wire logic       soOut,
  input  wire logic [7:0] byteOut,
  input  wire logic       soOeN,
  input  wire logic       byteOeN
);
  logic oddPhase;

  // Idle pins at time zero; link clock stands still outside frames
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    portByte = 1'b0;
    byteIn = 8'h00;
    oddPhase = 1'b0;
  end

  // Low phase of 6 or 7 cycles, high phase of 6: 12.5 cycles average
  task automatic lowPhase();
    repeat (6 + oddPhase) @(posedge sysClk);
    oddPhase = ~oddPhase;
  endtask : lowPhase

  task automatic sckPulse();
    lowPhase();
    sck <= 1'b1;
    repeat (6) @(posedge sysClk);
    sck <= 1'b0;
  endtask : sckPulse

  // Select; port choice changes on the same edge, so it is seen with the fall
  task automatic open(input logic pb);
    @(posedge sysClk);
    portByte <= pb;
    csN <= 1'b0;
    repeat (8) @(posedge sysClk);
  endtask : open

  // Serial MSB first, or one byte per rise on the byte port
  task automatic putByte(input logic [7:0] b);
    if (portByte)
    begin
      byteIn <= b;
      sckPulse();
    end
    else
      for (int i = 7; i >= 0; i--)
      begin
        si <= b[i];
        sckPulse();
      end
  endtask : putByte

  // Sample late in the low phase; a released output reads as its inverse
  task automatic getByte(output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < (portByte ? 1 : 8); i++)
    begin
      lowPhase();
      v = portByte ? (byteOeN ? ~byteOut : byteOut) : {v[6:0], soOeN ? ~soOut : soOut};
      sck <= 1'b1;
      repeat (6) @(posedge sysClk);
      sck <= 1'b0;
    end
  endtask : getByte

  // Deselect; released data lines show the inverse of their last value
  task automatic close();
    lowPhase();
    csN <= 1'b1;
    si <= ~si;
    byteIn <= ~byteIn;
    repeat (6) @(posedge sysClk);
  endtask : close

  // Command of n bytes, highest byte sent first
  task automatic cmd(input logic pb, input logic [31:0] bytes, input int n);
    open(pb);
    for (int i = n - 1; i >= 0; i--)
      putByte(bytes[8*i +: 8]);
    close();
  endtask : cmd
endmodule : host_link_model

// *** tb_status_power_pagesize_commands.sv ***
// Self-checking bench of the status, power-down and page-size commands.
// Assumes the host model above; short resume and program times.
`timescale 1ns/1ps
module tb_status_power_pagesize_commands;
  localparam logic [3:0] DENS = 4'h5; // Arbitrary density code
  logic       sysClk = 1'b0, arstN = 1'b0, csN, sck, si, portByte;
  logic [7:0] byteIn, byteOut, opcode;
  logic       soOut, soOeN, byteOeN, deepPowerDown, pageBinary, cfgProgStart;
  logic       opcodeValid, arrayBusy = 1'b0, compareDone = 1'b0;
  logic       compareMismatch = 1'b0, protectOn = 1'b0, nvCfgBinary = 1'b0;
  int         numErrors = 0, checksDone = 0, cycles = 0, cfgCount = 0, opCount = 0;

  host_link_model host (.sysClk(sysClk), .csN(csN), .sck(sck), .si(si),
    .portByte(portByte), .byteIn(byteIn), .soOut(soOut), .byteOut(byteOut), .soOeN(soOeN),
    .byteOeN(byteOeN));

  status_power_pagesize_commands #(.DENSITY_CODE(DENS), .PD_RESUME_NS(500),
    .CFG_PROG_NS(5000)) dut (.sys_clk(sysClk), .arst_n(arstN), .csN(csN),
    .sck(sck), .si(si), .portByte(portByte), .byteIn(byteIn), .soOut(soOut),
    .soOeN(soOeN), .byteOut(byteOut), .byteOeN(byteOeN), .arrayBusy(arrayBusy),
    .compareDone(compareDone), .compareMismatch(compareMismatch),
    .protectOn(protectOn), .nvCfgBinary(nvCfgBinary),
    .deepPowerDown(deepPowerDown), .pageBinary(pageBinary),
    .cfgProgStart(cfgProgStart), .opcodeValid(opcodeValid), .opcode(opcode));

  // 100 MHz system clock
  initial
  begin
    forever #5 sysClk = ~sysClk;
  end

  // Program-start pulses; timeout well above the expected run length
  always @(posedge sysClk)
  begin
    cycles <= cycles + 1;
    if (cfgProgStart === 1'b1)
      cfgCount <= cfgCount + 1;
    if (opcodeValid === 1'b1)
      opCount <= opCount + 1;
    if (cycles == 40000)
    begin
      numErrors = numErrors + 1;
      finishTest();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] expStat(input logic bsy, cmp, prt, pg);
    return {~bsy, cmp, DENS, prt, pg};
  endfunction : expStat

  // Status opcode, dummy clocks on the byte port, then one status byte
  task automatic readStat(input logic pb, output logic [7:0] v);
    host.open(pb);
    host.putByte(8'hd7);
    if (pb)
      repeat (2) host.getByte(v);
    host.getByte(v);
  endtask : readStat

  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finishTest

  // Main sequence
  initial
  begin
    logic [7:0] v, op;
    logic       b, m, p, pb;
    void'($urandom(72));
    repeat (20) @(posedge sysClk);
    arstN <= 1'b1;
    repeat (4) @(posedge sysClk);
    check("standby", deepPowerDown, 1'b0);
    check("page size", pageBinary, 1'b0);
    p = 1'($urandom_range(1));
    protectOn <= p;
    readStat(1'b0, v);
    check("serial status", v, expStat(0, 0, p, 0));
    check("so enable", soOeN, 1'b0);
    protectOn <= ~p;
    repeat (2) host.getByte(v);
    check("repeat status", v, expStat(0, 0, ~p, 0));
    host.close();
    check("so released", soOeN, 1'b1);
    $display("test status basic done");
    for (int k = 0; k < 6; k++)
    begin
      b = (k == 0) ? 1'b1 : 1'($urandom_range(1));
      m = 1'($urandom_range(1));
      p = 1'($urandom_range(1));
      pb = (k == 0) ? 1'b1 : 1'($urandom_range(1));
      arrayBusy <= b;
      protectOn <= p;
      compareDone <= 1'b1;
      compareMismatch <= m;
      @(posedge sysClk);
      compareDone <= 1'b0;
      compareMismatch <= ~m;
      readStat(pb, v);
      check("status", v, expStat(b, m, p, 0));
      if (pb)
        check("byte enable", byteOeN, 1'b0);
      host.close();
    end
    arrayBusy <= 1'b0;
    // Random opcode below 3DH: none of them opens a handled command, so it is forwarded
    op = 8'($urandom_range(32'h3c));
    host.cmd(1'b0, {24'h000000, op}, 1);
    check("forwarded opcode", opcode, op);
    check("forward count", 8'(opCount), 8'h01);
    $display("test random status done");
    host.cmd(1'b0, 32'hb9, 1);
    for (int i = 0; i < 400 && deepPowerDown !== 1'b1; i++)
      @(posedge sysClk);
    check("enter deep", deepPowerDown, 1'b1);
    readStat(1'b1, v);
    check("deep ignores", byteOeN, 1'b1);
    host.close();
    host.cmd(1'b0, 32'hab, 1);
    repeat (10) @(posedge sysClk);
    check("resume", deepPowerDown, 1'b0);
    repeat (60) @(posedge sysClk);
    readStat(1'b0, v);
    host.close();
    check("status after resume", v, expStat(0, m, p, 0));
    $display("test power down done");
    host.cmd(1'b0, 32'h3d2a81a6, 4);
    repeat (10) @(posedge sysClk);
    check("bad sequence", 8'(cfgCount), 8'h00);
    host.cmd(1'b0, 32'h3d2a80a6, 4);
    repeat (10) @(posedge sysClk);
    check("program start", 8'(cfgCount), 8'h01);
    host.cmd(1'b1, {24'h000000, op}, 1);
    check("held while busy", 8'(opCount), 8'h01);
    readStat(1'b0, v);
    host.close();
    check("config busy", v[7], 1'b0);
    repeat (600) @(posedge sysClk);
    readStat(1'b0, v);
    host.close();
    check("binary flag", v, expStat(0, m, p, 1));
    check("size deferred", pageBinary, 1'b0);
    host.cmd(1'b1, 32'h3d2a80a6, 4);
    repeat (10) @(posedge sysClk);
    check("one time", 8'(cfgCount), 8'h01);
    $display("test page size done");
    nvCfgBinary <= 1'b1;
    arstN <= 1'b0;
    repeat (20) @(posedge sysClk);
    arstN <= 1'b1;
    repeat (4) @(posedge sysClk);
    check("size after cycle", pageBinary, 1'b1);
    readStat(1'b1, v);
    host.close();
    check("status bit0", v[0], 1'b1);
    $display("test power cycle done");
    finishTest();
  end
endmodule : tb_status_power_pagesize_commands
